/* dv/mdsc_host.sv */
// Serial host model: frame sync, serial clock, data-in and readback capture.
`timescale 1ns/1ps
module mdsc_host (
  // Serial lines.
  output logic      sync_n_o,
  output logic      sclk_o,
  output logic      din_o,
  input  wire logic dout_i,
  input  wire logic dout_oe_n_i
);
  initial {sync_n_o, sclk_o, din_o} = 3'h4;
  // Sends the n leading bits of w; a released data-out reads as the inverse.
  task automatic xfer(input logic [23:0] w, input int n, output logic [13:0] rd);
    #503 sync_n_o = 1'h0;  // gap before every frame
    #50;
    for (int i = 0; i < n + 2; i++) begin  // two surplus clocks are ignored
      sclk_o = 1'h1;
      din_o  = (i < n) ? w[23-i] : ~din_o;  // MSB first
      #40 sclk_o = 1'h0;
      #15 if (i < 14) rd[13-i] = dout_oe_n_i ? ~dout_i : dout_i;
      #25;
    end
    sync_n_o = 1'h1;
    din_o    = ~din_o;
  endtask : xfer
endmodule : mdsc_host

/* dv/mdsc_top_asserts.sv */
// Concurrent checks on the serial and acquisition pins of the DAC control block.
`timescale 1ns/1ps
module mdsc_top_asserts #(
  parameter int CAL_CYCLES_P = 60
) (
  // Watched pins.
  input wire logic                         clk_sys_i,
  input wire logic                         rst_i,
  input wire logic                         interface_select_i,
  input wire logic                         track_n_i,
  input wire logic                         dout_o,
  input wire logic                         dout_oe_n_o,
  input wire logic                         busy_n_o,
  input wire logic [mdsc_pkg::NUM_DAC-1:0] vin_route_o
);
  import mdsc_pkg::*;
  logic [12:0] busy_cnt_r;
  logic [12:0] oe_cnt_r;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // Low-time counters of busy and of the data-out enable
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      busy_cnt_r <= '0;
      oe_cnt_r   <= '0;
    end else begin
      busy_cnt_r <= busy_n_o ? '0 : busy_cnt_r + 13'h1;
      oe_cnt_r   <= dout_oe_n_o ? '0 : oe_cnt_r + 13'h1;
    end
  end
  property p_busy_len; $rose(busy_n_o) |-> busy_cnt_r inside {[ACQ_CYCLES-2:ACQ_CYCLES+2],
    [CAL_CYCLES_P-2:CAL_CYCLES_P+2]}; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy low time off");
  property p_busy_max; !busy_n_o |-> busy_cnt_r <= ((CAL_CYCLES_P > ACQ_CYCLES) ? CAL_CYCLES_P : ACQ_CYCLES) + 2;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("acquisition too long");
  property p_route; $fell(busy_n_o) |-> $countones(vin_route_o) inside {1, 32}; endproperty
  a_route: assert property (p_route) else $error("wrong channels routed");
  property p_trk_wait; !track_n_i [*6] ##0 busy_n_o |=> busy_n_o; endproperty
  a_trk_wait: assert property (p_trk_wait) else $error("acquired with track low");
  property p_oe_len; $rose(dout_oe_n_o) |-> oe_cnt_r inside {[104:112]}; endproperty
  a_oe_len: assert property (p_oe_len) else $error("readback drive length off");
  property p_oe_end; $rose(dout_oe_n_o) |=> dout_oe_n_o [*8]; endproperty
  a_oe_end: assert property (p_oe_end) else $error("drive after last bit");
  property p_dout_hold; $changed(dout_o) |-> !dout_oe_n_o || !$past(dout_oe_n_o); endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("data out moved while released");
  property p_isel; !interface_select_i [*8] |-> dout_oe_n_o && busy_n_o; endproperty
  a_isel: assert property (p_isel) else $error("serial activity while deselected");
endmodule : mdsc_top_asserts
bind mdsc_top mdsc_top_asserts #(.CAL_CYCLES_P(CAL_CYCLES_P)) i_mdsc_top_asserts (.clk_sys_i, .rst_i,
  .interface_select_i, .track_n_i, .dout_o, .dout_oe_n_o, .busy_n_o, .vin_route_o);

/* dv/mdsc_top_tb.sv */
// Self-checking bench of the DAC serial control block.
`timescale 1ns/1ps
module mdsc_top_tb;
  import mdsc_pkg::*;
  logic clk_sys_i = 1'h0, rst_i = 1'h1, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic interface_select_i = 1'h1, track_n_i = 1'h1;
  logic pready_o, pslverr_o, sync_n_i, sclk_i, din_i, dout_o, dout_oe_n_o, busy_n_o;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o;
  logic [NUM_DAC-1:0] vin_route_o;
  int bad_count = 0, checked = 0;
  mdsc_top #(.CAL_CYCLES_P(60)) i_mdsc_top (.clk_sys_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .interface_select_i, .sync_n_i, .sclk_i, .din_i,
    .dout_o, .dout_oe_n_o, .track_n_i, .busy_n_o, .vin_route_o);
  mdsc_host i_mdsc_host (.sync_n_o(sync_n_i), .sclk_o(sclk_i), .din_o(din_i), .dout_i(dout_o),
    .dout_oe_n_i(dout_oe_n_o));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  function automatic logic [23:0] word(logic [1:0] m, logic cal, logic ofs, logic [4:0] ch, logic [13:0] c);
    return {m, cal, ofs, 1'h0, ch, c};
  endfunction : word
  function automatic logic [11:0] dadr(logic [5:0] ch);
    return OFS_DAC_BASE + {4'h0, ch, 2'h0};
  endfunction : dadr
  task automatic wrap_up();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int k;
    @(posedge clk_sys_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'h2, w, a, d};
    @(posedge clk_sys_i);
    penable_i <= 1'h1;
    for (k = 0; k < 50 && pready_o !== 1'h1; k++) @(posedge clk_sys_i);
    r = prdata_o;
    e = pslverr_o;
    {psel_i, penable_i} <= 2'h0;
    if (k == 50) begin
      bad_count++;
      wrap_up();
    end
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'h0, a, '0, r, e);
    chk(r, x);
  endtask : rchk
  task automatic wbusy(input logic lvl);
    int k;
    for (k = 0; k < 3000 && busy_n_o !== lvl; k++) @(posedge clk_sys_i);
    if (k == 3000) begin
      bad_count++;
      wrap_up();
    end
  endtask : wbusy
  initial begin
    logic [31:0] r;
    logic        e;
    logic [13:0] rd, c, c2;
    logic [4:0]  ch;
    void'($urandom(32'h43a913c8));
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    repeat (6) @(posedge clk_sys_i);
    rchk(OFS_STATUS, 32'h14);
    apb(1'h1, OFS_STATUS, '1, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'h0, 12'hFFC, '0, r, e);
    chk({31'h0, e}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      ch = (i == 0) ? 5'h1F : 5'($urandom);
      c  = (i == 0) ? 14'h2AAB : 14'($urandom);
      i_mdsc_host.xfer(word(MODE_DAC_LOAD, 1'h0, 1'h0, ch, c), 24, rd);
      rchk(dadr({1'h0, ch}), {18'h0, c});
      i_mdsc_host.xfer(word(MODE_RB_ONLY, 1'h0, 1'h0, ch, 14'($urandom)), 10, rd);
      i_mdsc_host.xfer(24'($urandom), 14, rd);
      chk({18'h0, rd}, {18'h0, c});
      chk({31'h0, busy_n_o}, 32'h1);
    end
    c2 = 14'($urandom);
    i_mdsc_host.xfer(word(MODE_DAC_LOAD, 1'h0, 1'h1, ch, c2), 24, rd);
    rchk(dadr(OFFSET_CHAN), {18'h0, c2});
    rchk(dadr({1'h0, ch}), {18'h0, c});
    i_mdsc_host.xfer(word(MODE_DAC_LOAD, 1'h1, 1'h0, ch, 14'h3FFF), 24, rd);
    rchk(dadr(6'h00), 32'h3FFF);
    rchk(dadr(6'h1F), 32'h3FFF);
    rchk(dadr(OFFSET_CHAN), {18'h0, c2});
    for (int m = 0; m < 3; m++) begin
      c = 14'($urandom);
      apb(1'h1, OFS_ACQ_CODE, {18'h0, c}, r, e);
      i_mdsc_host.xfer(word((m == 2) ? MODE_ACQ_RB : MODE_ACQ_TO_DAC, m == 1, 1'h0, ch, '0), 10, rd);
      wbusy(1'h0);
      wbusy(1'h1);  // full acquisition before readback
      rchk(dadr({1'h0, (m == 1) ? ~ch : ch}), {18'h0, c});
      if (m == 2) begin
        i_mdsc_host.xfer(24'($urandom), 14, rd);
        chk({18'h0, rd}, {18'h0, c});
      end
    end
    @(posedge clk_sys_i);
    track_n_i <= 1'h0;
    c = 14'($urandom);
    apb(1'h1, OFS_ACQ_CODE, {18'h0, c}, r, e);
    i_mdsc_host.xfer(word(MODE_ACQ_TO_DAC, 1'h0, 1'h0, ch, '0), 10, rd);
    repeat (40) @(posedge clk_sys_i);
    chk({31'h0, busy_n_o}, 32'h1);
    chk({31'h0, vin_route_o[ch]}, 32'h1);
    track_n_i <= 1'h1;
    wbusy(1'h0);
    wbusy(1'h1);
    rchk(dadr({1'h0, ch}), {18'h0, c});
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_sys_i);
      track_n_i <= 1'h0;
      repeat (j ? 14 : 5) @(posedge clk_sys_i);
      track_n_i <= 1'h1;
      repeat (10) @(posedge clk_sys_i);
      rchk(dadr({1'h0, ch}), j ? 32'h0 : {18'h0, c});
    end
    @(posedge clk_sys_i);
    interface_select_i <= 1'h0;
    i_mdsc_host.xfer(word(MODE_DAC_LOAD, 1'h0, 1'h0, ch, 14'h1555), 24, rd);
    @(posedge clk_sys_i);
    interface_select_i <= 1'h1;
    rchk(dadr({1'h0, ch}), 32'h0);
    wrap_up();
  end
endmodule : mdsc_top_tb

/* logic/mdsc_pkg.sv */
// Shared constants, types and register map of the multichannel DAC serial control block.
package mdsc_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS  = 10;
  localparam int ACQ_TIME_NS    = 16000;
  localparam int CAL_TIME_NS    = 45000;
  localparam int RST_MIN_NS     = 90;
  localparam int RST_MAX_NS     = 200;
  localparam int ACQ_CYCLES     = ACQ_TIME_NS / CLK_PERIOD_NS;
  localparam int CAL_CYCLES     = CAL_TIME_NS / CLK_PERIOD_NS;
  localparam int RST_MIN_CYCLES = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_MAX_CYCLES = RST_MAX_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Serial word layout
  // ==========================================================================
  localparam int ADDR_BITS  = 10;
  localparam int DATA_BITS  = 14;
  localparam int LOAD_BITS  = 24;
  localparam int MODE_BITS  = 2;
  localparam int NUM_CHAN   = 32;
  localparam int NUM_DAC    = 33;
  localparam logic [5:0] OFFSET_CHAN = 6'h20;

  localparam logic [1:0] MODE_ACQ_TO_DAC = 2'h0;
  localparam logic [1:0] MODE_DAC_LOAD   = 2'h1;
  localparam logic [1:0] MODE_ACQ_RB     = 2'h2;
  localparam logic [1:0] MODE_RB_ONLY    = 2'h3;

  typedef struct packed {
    logic [1:0] mode;
    logic       cal;
    logic       offs_sel;
    logic       test;
    logic [4:0] channel_address;
  } mdsc_addr_word_t;

  // ==========================================================================
  // Synchronised pin indices
  // ==========================================================================
  localparam int PIN_SYNC  = 0;
  localparam int PIN_SCLK  = 1;
  localparam int PIN_DIN   = 2;
  localparam int PIN_TRACK = 3;
  localparam int PIN_ISEL  = 4;
  localparam int NUM_PINS  = 5;
  localparam logic [4:0] PIN_RESET_VAL = 5'h19;

  // ==========================================================================
  // APB register map
  // ==========================================================================
  localparam logic [11:0] OFS_STATUS    = 12'h000;
  localparam logic [11:0] OFS_ACQ_CODE  = 12'h004;
  localparam logic [11:0] OFS_LAST_WORD = 12'h008;
  localparam logic [11:0] OFS_DAC_BASE  = 12'h100;
  localparam logic [13:0] ACQ_CODE_RST  = 14'h0000;
  localparam logic [13:0] DAC_CODE_RST  = 14'h0000;
  localparam int STAT_ACQ_RUN  = 0;
  localparam int STAT_TRK_WAIT = 1;
  localparam int STAT_ISEL     = 2;
  localparam int STAT_SER_LSB  = 4;

  typedef enum logic [4:0] {
    SER_IDLE   = 5'h01,
    SER_SHIFT  = 5'h02,
    SER_RB_ARM = 5'h04,
    SER_RB_OUT = 5'h08,
    SER_HOLD   = 5'h10
  } mdsc_ser_state_t;

  typedef enum logic [2:0] {
    AQ_IDLE = 3'h1,
    AQ_WAIT = 3'h2,
    AQ_RUN  = 3'h4
  } mdsc_acq_state_t;

endpackage : mdsc_pkg

/* logic/mdsc_top.sv */
// Serial command interface, DAC code store and acquisition control of the 32-channel DAC.
//
// Functional notes
// - First two serial bits choose mode: acquire, DAC load, acquire+readback, readback.
// - Acquire mode takes a 10-bit MSB-first word selecting one, offset or all channels.
// - DAC load takes 24 bits MSB first: 10 address bits, then 14 data bits.
// - Acquire+readback acquires in 16 us (45 us with calibrate), reads 14 bits after next frame fall.
// - Readback-only performs no acquisition; outputs 14 bits after next frame fall.
// - First frame fall clears bit counter; further frame edges ignored until done.
// - After the required bit count, clocks are ignored until a new frame fall.
// - Works with free-running clock or clock that runs only during transfers.
// - Data-out enabled on first clock rise, updated each rise, released on 14th fall.
// - Data-in sampled on every clock fall from the first; ignored during readback.
// - Serial interface active only while interface select is high.
// - Calibrate bit: DAC mode loads all 32 alike; acquire mode acquires all 32.
// - Offset-select bit targets offset channel and ignores channel address.
// - Five-bit channel address, first bit most significant, picks one of 32.
// - Data bits write the addressed DAC register only in DAC load mode.
// - Track high when addressed starts the acquisition at once.
// - Track low routes input to the buffer and waits for track rising.
// - Busy is low during acquisition; afterwards the DAC drives the buffer.
// - Track low pulse of 90 to 200 ns resets all but the acquisition code register; shorter is ignored.
`timescale 1ns/1ps

module mdsc_top #(
  parameter int CAL_CYCLES_P = mdsc_pkg::CAL_CYCLES
) (
  // Clock and reset.
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_i,
  // APB slave.
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [11:0]                paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  // Serial pins.
  input  wire logic                       interface_select_i,
  input  wire logic                       sync_n_i,
  input  wire logic                       sclk_i,
  input  wire logic                       din_i,
  output logic                            dout_o,
  output logic                            dout_oe_n_o,
  // Acquisition control.
  input  wire logic                       track_n_i,
  output logic                            busy_n_o,
  output logic [mdsc_pkg::NUM_DAC-1:0]    vin_route_o
);
  import mdsc_pkg::*;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [5:0] target_chan(input mdsc_addr_word_t aw);
    target_chan = aw.offs_sel ? OFFSET_CHAN : {1'b0, aw.channel_address};
  endfunction : target_chan

  function automatic logic [NUM_DAC-1:0] chan_mask(input logic [5:0] ch, input logic all);
    chan_mask = all ? {1'b0, {NUM_CHAN{1'b1}}} : ({{(NUM_DAC-1){1'b0}}, 1'b1} << ch);
  endfunction : chan_mask

  // ==========================================================================
  // Pin synchronisers and edge detection
  // ==========================================================================
  logic [NUM_PINS-1:0] pin_s1_r;
  logic [NUM_PINS-1:0] pin_s2_r;
  logic [NUM_PINS-1:0] pin_s3_r;
  logic [NUM_PINS-1:0] pin_st_r;
  logic [NUM_PINS-1:0] pin_agree;
  logic [NUM_PINS-1:0] pin_st_nxt;
  logic [NUM_PINS-1:0] pin_fall;
  logic [NUM_PINS-1:0] pin_rise;

  assign pin_agree  = ~(pin_s2_r ^ pin_s3_r);
  assign pin_st_nxt = (pin_st_r & ~pin_agree) | (pin_s3_r & pin_agree);
  assign pin_fall   = pin_st_r & ~pin_st_nxt;
  assign pin_rise   = ~pin_st_r & pin_st_nxt;

  // Edges are found from sampled levels, so the clock may stop between frames.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_r <= PIN_RESET_VAL;
      pin_s2_r <= PIN_RESET_VAL;
      pin_s3_r <= PIN_RESET_VAL;
      pin_st_r <= PIN_RESET_VAL;
    end else begin
      pin_s1_r <= {interface_select_i, track_n_i, din_i, sclk_i, sync_n_i};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_st_r <= pin_st_nxt;
    end
  end

  // ==========================================================================
  // Track/reset pulse measurement
  // ==========================================================================
  logic [4:0] trk_low_r;
  logic [4:0] trk_low_nxt;
  logic       soft_rst;
  logic       track_go;

  assign trk_low_nxt = pin_st_r[PIN_TRACK] ? 5'h00 :
                       ((trk_low_r == 5'h1F) ? trk_low_r : trk_low_r + 5'h01);
  // The counter holds one less than the low time in the cycle the rise is seen.
  assign soft_rst    = pin_rise[PIN_TRACK] && (trk_low_r >= 5'(RST_MIN_CYCLES - 1))
                       && (trk_low_r <= 5'(RST_MAX_CYCLES - 1));
  assign track_go    = pin_rise[PIN_TRACK] && (trk_low_r > 5'(RST_MAX_CYCLES - 1));

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      trk_low_r <= 5'h00;
    end else begin
      trk_low_r <= trk_low_nxt;
    end
  end

  // ==========================================================================
  // Serial shifter
  // ==========================================================================
  mdsc_ser_state_t     ser_r;
  mdsc_ser_state_t     ser_nxt;
  logic [4:0]          cnt_r;
  logic [4:0]          cnt_nxt;
  logic [LOAD_BITS-1:0] sh_in_r;
  logic [LOAD_BITS-1:0] sh_in_nxt;
  logic [1:0]          mode_r;
  logic [DATA_BITS-1:0] sh_out_r;
  logic [5:0]          rb_ch_r;
  logic [ADDR_BITS-1:0] last_word_r;
  logic                dout_r;
  logic                dout_oe_n_r;
  logic                ser_on;
  logic                sclk_fall;
  logic                sclk_rise;
  logic                sync_fall;
  logic [4:0]          need_bits;
  logic                shift_done;
  mdsc_addr_word_t     aw;
  logic [DATA_BITS-1:0] aw_data;
  logic                cmd_load;
  logic                cmd_acq;
  logic                cmd_rb;
  logic                rb_last;

  assign ser_on     = pin_st_r[PIN_ISEL];
  assign sclk_fall  = pin_fall[PIN_SCLK];
  assign sclk_rise  = pin_rise[PIN_SCLK];
  assign sync_fall  = pin_fall[PIN_SYNC];
  assign cnt_nxt    = cnt_r + 5'h01;
  assign sh_in_nxt  = {sh_in_r[LOAD_BITS-2:0], pin_st_r[PIN_DIN]};
  assign need_bits  = (mode_r == MODE_DAC_LOAD) ? 5'(LOAD_BITS) : 5'(ADDR_BITS);
  assign shift_done = (ser_r == SER_SHIFT) && sclk_fall && (cnt_nxt >= 5'(ADDR_BITS))
                      && (cnt_nxt == need_bits);
  // A 24-bit word holds the address in its top ten bits.
  assign aw         = (mode_r == MODE_DAC_LOAD) ? mdsc_addr_word_t'(sh_in_nxt[LOAD_BITS-1:DATA_BITS])
                                                : mdsc_addr_word_t'(sh_in_nxt[ADDR_BITS-1:0]);
  assign aw_data    = sh_in_nxt[DATA_BITS-1:0];
  assign cmd_load   = shift_done && (aw.mode == MODE_DAC_LOAD);
  assign cmd_acq    = shift_done && ((aw.mode == MODE_ACQ_TO_DAC) || (aw.mode == MODE_ACQ_RB));
  assign cmd_rb     = shift_done && aw.mode[1];
  assign rb_last    = (ser_r == SER_RB_OUT) && sclk_fall && (cnt_nxt == 5'(DATA_BITS));

  always_comb begin
    ser_nxt = ser_r;
    case (ser_r)
      SER_IDLE, SER_HOLD: ser_nxt = sync_fall ? SER_SHIFT : ser_r;
      SER_SHIFT:          ser_nxt = shift_done ? (cmd_rb ? SER_RB_ARM : SER_HOLD) : ser_r;
      SER_RB_ARM:         ser_nxt = sync_fall ? SER_RB_OUT : ser_r;
      SER_RB_OUT:         ser_nxt = rb_last ? SER_HOLD : ser_r;
      default: ser_nxt = SER_IDLE;
    endcase
    if (!ser_on || soft_rst) begin
      ser_nxt = SER_IDLE;
    end
  end

  logic [DATA_BITS-1:0] dac_mem [NUM_DAC];

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ser_r <= SER_IDLE;
    end else begin
      ser_r <= ser_nxt;
    end
  end

  // Frame edges inside SER_SHIFT and SER_RB_OUT leave the counter alone.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 5'h00;
    end else if (sync_fall && (ser_r != SER_SHIFT) && (ser_r != SER_RB_OUT)) begin
      cnt_r <= 5'h00;
    end else if (sclk_fall && ((ser_r == SER_SHIFT) || (ser_r == SER_RB_OUT))) begin
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sh_in_r     <= '0;
      mode_r      <= MODE_ACQ_TO_DAC;
      rb_ch_r     <= 6'h00;
      last_word_r <= '0;
    end else if (soft_rst) begin
      sh_in_r     <= '0;
      mode_r      <= MODE_ACQ_TO_DAC;
      rb_ch_r     <= 6'h00;
      last_word_r <= '0;
    end else if ((ser_r == SER_SHIFT) && sclk_fall) begin
      sh_in_r <= sh_in_nxt;
      if (cnt_nxt == 5'(MODE_BITS)) begin
        mode_r <= sh_in_nxt[1:0];
      end
      if (shift_done) begin
        rb_ch_r     <= target_chan(aw);
        last_word_r <= aw;
      end
    end
  end

  // Readback shifter; data-in is not looked at in these states.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sh_out_r    <= '0;
      dout_r      <= 1'b0;
      dout_oe_n_r <= 1'b1;
    end else if (!ser_on || soft_rst) begin
      dout_oe_n_r <= 1'b1;
    end else if ((ser_r == SER_RB_ARM) && sync_fall) begin
      sh_out_r <= dac_mem[rb_ch_r];
    end else if ((ser_r == SER_RB_OUT) && sclk_rise) begin
      dout_r      <= sh_out_r[DATA_BITS-1];
      sh_out_r    <= {sh_out_r[DATA_BITS-2:0], 1'b0};
      dout_oe_n_r <= 1'b0;
    end else if (rb_last) begin
      dout_oe_n_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Acquisition control
  // ==========================================================================
  mdsc_acq_state_t    aq_r;
  mdsc_acq_state_t    aq_nxt;
  logic [12:0]        aq_cnt_r;
  logic [NUM_DAC-1:0] aq_mask_r;
  logic               aq_all_r;
  logic [13:0]        acq_code_r;
  logic               aq_done;
  logic [12:0]        aq_len;
  logic [NUM_DAC-1:0] route_nxt;
  logic [NUM_DAC-1:0] cmd_mask;

  assign aq_len    = aq_all_r ? 13'(CAL_CYCLES_P) : 13'(ACQ_CYCLES);
  assign aq_done   = (aq_r == AQ_RUN) && (aq_cnt_r == aq_len - 13'h0001);
  assign cmd_mask  = chan_mask(target_chan(aw), aw.cal);
  assign route_nxt = (aq_nxt == AQ_IDLE) ? '0 : (cmd_acq ? cmd_mask : aq_mask_r);

  always_comb begin
    aq_nxt = aq_r;
    case (aq_r)
      AQ_IDLE: aq_nxt = aq_r;
      AQ_WAIT: aq_nxt = track_go ? AQ_RUN : aq_r;
      AQ_RUN:  aq_nxt = aq_done ? AQ_IDLE : aq_r;
      default: aq_nxt = AQ_IDLE;
    endcase
    if (cmd_acq) begin
      aq_nxt = pin_st_r[PIN_TRACK] ? AQ_RUN : AQ_WAIT;
    end
    if (soft_rst) begin
      aq_nxt = AQ_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      aq_r      <= AQ_IDLE;
      aq_cnt_r  <= 13'h0000;
      aq_mask_r <= '0;
      aq_all_r  <= 1'b0;
    end else begin
      aq_r <= aq_nxt;
      if (cmd_acq) begin
        aq_mask_r <= cmd_mask;
        aq_all_r  <= aw.cal;
      end
      aq_cnt_r <= ((aq_r == AQ_RUN) && (aq_nxt == AQ_RUN) && !cmd_acq) ? aq_cnt_r + 13'h0001 : 13'h0000;
    end
  end

  // Conversion result store: acquisitions and DAC loads.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_DAC; i++) begin
        dac_mem[i] <= DAC_CODE_RST;
      end
    end else if (soft_rst) begin
      for (int i = 0; i < NUM_DAC; i++) begin
        dac_mem[i] <= DAC_CODE_RST;
      end
    end else if (cmd_load) begin
      for (int i = 0; i < NUM_DAC; i++) begin
        if (cmd_mask[i]) begin
          dac_mem[i] <= aw.cal ? {DATA_BITS{aw_data[DATA_BITS-1]}} : aw_data;
        end
      end
    end else if (aq_done) begin
      for (int i = 0; i < NUM_DAC; i++) begin
        if (aq_mask_r[i]) begin
          dac_mem[i] <= acq_code_r;
        end
      end
    end
  end

  logic                busy_n_r;
  logic [NUM_DAC-1:0]  route_r;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      busy_n_r <= 1'b1;
      route_r  <= '0;
    end else begin
      busy_n_r <= (aq_nxt != AQ_RUN);
      route_r  <= route_nxt;
    end
  end

  // ==========================================================================
  // APB slave
  // ==========================================================================
  logic        apb_setup;
  logic        apb_wr;
  logic        hit_dac;
  logic [5:0]  dac_idx;
  logic        hit_any;
  logic [31:0] rd_mux;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  assign apb_setup = psel_i && !penable_i;
  assign apb_wr    = psel_i && penable_i && pready_r && pwrite_i;
  assign dac_idx   = 6'(({paddr_i[11:2], 2'b00} - OFS_DAC_BASE) >> 2);
  assign hit_dac   = (paddr_i >= OFS_DAC_BASE) && (paddr_i[1:0] == 2'b00)
                     && (paddr_i < 12'(OFS_DAC_BASE + 4 * NUM_DAC))
                     && !pwrite_i;
  assign hit_any   = hit_dac || (paddr_i == OFS_ACQ_CODE) ||
                     (!pwrite_i && ((paddr_i == OFS_STATUS) || (paddr_i == OFS_LAST_WORD)));
  assign rd_mux    = hit_dac ? {18'h00000, dac_mem[dac_idx]} :
                     (paddr_i == OFS_STATUS) ? {23'h000000, ser_r, 1'b0, ser_on, (aq_r == AQ_WAIT),
                                                (aq_r == AQ_RUN)} :
                     (paddr_i == OFS_ACQ_CODE) ? {18'h00000, acq_code_r} :
                     (paddr_i == OFS_LAST_WORD) ? {22'h000000, last_word_r} : 32'h00000000;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= apb_setup;
      if (apb_setup) begin
        prdata_r  <= pwrite_i ? 32'h00000000 : rd_mux;
        pslverr_r <= !hit_any;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      acq_code_r <= ACQ_CODE_RST;
    end else if (apb_wr && (paddr_i == OFS_ACQ_CODE)) begin
      acq_code_r <= pwdata_i[DATA_BITS-1:0];
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign prdata_o    = prdata_r;
  assign pready_o    = pready_r;
  assign pslverr_o   = pslverr_r;
  assign dout_o      = dout_r;
  assign dout_oe_n_o = dout_oe_n_r;
  assign busy_n_o    = busy_n_r;
  assign vin_route_o = route_r;

endmodule : mdsc_top
